//--- src/config_pin_status_signal_logic.v
// status pin functions: charger detect, lamps, suspend, wake, config load
`timescale 1ns/10ps
// Behaviour
// (RL1) detect charging port as shorted data lines while suspended
// (RL2) shorted data lines mean suspend, not enumeration
// (RL3) charger output asserts on a configured pin after detection in suspend
// (RL4) a pin may carry the active-low charger output instead
// (RL5) charger output inactive while enumerated and not suspended
// (RL6) any pin may carry transmit, receive or activity lamp
// (RL7) lamp pins drive low during activity, otherwise high impedance
// (RL8) each lamp activation stretched by a digital one-shot
// (RL9) activity lamp lit for either transmit or receive
// (RL10) after power-on or bus reset, load config before answering host
// (RL11) optional pull-down of UART lines during suspend, default off
// (RL12) wake line low in suspend signals resume when enabled, default on
// (RL13) report descriptor version code 0200 at full speed
// (RL14) default max power ninety milliamps, bus powered
// (RL15) serial number enabled by default, value from config memory
// (RL16) suspend indicator pin low in suspend, high otherwise
// (RL17) one-shot length fixed cycle count, tens of milliseconds, retriggerable
// (RL18) unassigned pins high impedance, one function per pin
`include "config_pin_status_defines.vh"

module config_pin_status_signal_logic #(
    parameter PINS        = 4,
    parameter LAMP_CYCLES = (`CLK_HZ / 1000) * `LAMP_MS,
    parameter WAKE_CYCLES = (`CLK_HZ / 1000) * `RESUME_MS,
    parameter [31:0] SERIAL_DEFAULT = 32'h1234_5678 // arbitrary value
) (
    // clock and reset
    input  wire             clk,
    input  wire             sys_rst,
    // axi4-lite write address
    input  wire [7:0]       s_axi_awaddr,
    input  wire             s_axi_awvalid,
    output wire             s_axi_awready,
    // axi4-lite write data
    input  wire [31:0]      s_axi_wdata,
    input  wire [3:0]       s_axi_wstrb,
    input  wire             s_axi_wvalid,
    output wire             s_axi_wready,
    // axi4-lite write response
    output reg  [1:0]       s_axi_bresp,
    output reg              s_axi_bvalid,
    input  wire             s_axi_bready,
    // axi4-lite read
    input  wire [7:0]       s_axi_araddr,
    input  wire             s_axi_arvalid,
    output wire             s_axi_arready,
    output reg  [31:0]      s_axi_rdata,
    output reg  [1:0]       s_axi_rresp,
    output reg              s_axi_rvalid,
    input  wire             s_axi_rready,
    // usb side status
    input  wire             usbBusReset,
    input  wire             usbSuspend,
    input  wire             dataLinesShorted,
    input  wire             enumerated,
    output reg              resumeSignal,
    output reg              configLoaded,
    // uart activity
    input  wire             txActive,
    input  wire             rxActive,
    input  wire             wake_line_n,
    output reg              uartPullDown,
    // config pins (two signals each)
    output reg  [PINS-1:0]  configPinOut,
    output reg  [PINS-1:0]  configPinOe
);

    // state codes of the config load sequence
    localparam LD_IDLE = 1'b0;
    localparam LD_BUSY = 1'b1;

    // registers
    // stretch and wake counters are 32 bits so full-length counts fit
    reg [4*PINS-1:0] pinFunc;
    reg [31:0]       options;
    reg [31:0]       serialNum;
    reg              loadState;
    reg [7:0]        loadCount;
    reg              chargePortSeen;
    reg [31:0]       txStretch;
    reg [31:0]       rxStretch;
    reg [31:0]       wakeCount;
    reg              wakeLatched;
    reg              awTaken;
    reg              wTaken;
    reg [7:0]        awAddr;
    reg [31:0]       wData;
    reg [3:0]        wStrb;

    // a lamp stays lit while its one-shot counter runs
    wire txLamp  = (txStretch != 32'h0000_0000);
    wire rxLamp  = (rxStretch != 32'h0000_0000);

    // byte-lane merge of a write
    function [31:0] merge;
        input [31:0] old;
        input [31:0] dat;
        input [3:0]  stb;
        integer      b;
        begin
            // lanes without a strobe keep their old bits
            merge = old;
            for (b = 0; b < 4; b = b + 1) begin
                if (stb[b])
                    merge[8*b +: 8] = dat[8*b +: 8];
            end
        end
    endfunction

    // address map check
    // anything else answers with a slave error
    function mapped;
        input [7:0] a;
        begin
            mapped = (a == `OFS_PIN_FUNC) || (a == `OFS_OPTIONS) || (a == `OFS_STATUS) ||
                     (a == `OFS_DESC_INFO) || (a == `OFS_SERIAL) || (a == `OFS_LOAD_CTRL);
        end
    endfunction

    // write channel handshakes
    // ready drops while a response waits: one write in flight
    assign s_axi_awready = !awTaken && !s_axi_bvalid;
    assign s_axi_wready  = !wTaken && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    wire [7:0]  curAw  = awTaken ? awAddr : s_axi_awaddr;
    wire [31:0] curW   = wTaken ? wData : s_axi_wdata;
    wire [3:0]  curS   = wTaken ? wStrb : s_axi_wstrb;
    wire        haveAw = awTaken || (s_axi_awvalid && s_axi_awready);
    wire        haveW  = wTaken || (s_axi_wvalid && s_axi_wready);
    wire        doWr   = haveAw && haveW;

    // merged pin word, cut to the pins that exist
    wire [31:0] pinMerge = merge({{(32-4*PINS){1'b0}}, pinFunc}, curW, curS);

    // axi write path and software registers
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            awTaken      <= 1'b0;
            wTaken       <= 1'b0;
            awAddr       <= 8'h00;
            wData        <= 32'h0000_0000;
            wStrb        <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RESP_OKAY;
            pinFunc      <= `RST_PIN_FUNC;
            options      <= `RST_OPTIONS;
        end else begin
            if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (doWr) begin
                awTaken      <= 1'b0;
                wTaken       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= mapped(curAw) ? `RESP_OKAY : `RESP_SLVERR;
                // (RL18) one code per pin
                if (curAw == `OFS_PIN_FUNC)
                    pinFunc <= pinMerge[4*PINS-1:0];
                if (curAw == `OFS_OPTIONS)
                    options <= merge(options, curW, curS) & 32'h0000_000F;
            end else begin
                if (s_axi_awvalid && s_axi_awready) begin
                    awTaken <= 1'b1;
                    awAddr  <= s_axi_awaddr;
                end
                if (s_axi_wvalid && s_axi_wready) begin
                    wTaken <= 1'b1;
                    wData  <= s_axi_wdata;
                    wStrb  <= s_axi_wstrb;
                end
            end
        end
    end

    // axi read path
    // arready low while rvalid stands: one read in flight
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
            case (s_axi_araddr)
                `OFS_PIN_FUNC:  s_axi_rdata <= {{(32-4*PINS){1'b0}}, pinFunc};
                `OFS_OPTIONS:   s_axi_rdata <= options;
                `OFS_STATUS:    s_axi_rdata <= {26'h000_0000, configLoaded, wakeLatched,
                                                rxLamp, txLamp, usbSuspend, chargePortSeen};
                // (RL13) version code, (RL14) power and source
                `OFS_DESC_INFO: s_axi_rdata <= {`DESC_USB_VERSION, 7'h00, options[`OPT_SELF_POWER],
                                                `DESC_MAX_POWER_MA};
                // (RL15) serial only when enabled
                `OFS_SERIAL:    s_axi_rdata <= options[`OPT_SERIAL_EN] ? serialNum : 32'h0000_0000;
                `OFS_LOAD_CTRL: s_axi_rdata <= {31'h0000_0000, loadState};
                default:        s_axi_rdata <= 32'h0000_0000;
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // (RL10) config scan after resets
    // a bus reset during a running scan does not restart it
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            loadState    <= LD_BUSY;
            loadCount    <= 8'h00;
            configLoaded <= 1'b0;
            serialNum    <= 32'h0000_0000;
        end else begin
            case (loadState)
                LD_IDLE: begin
                    if (usbBusReset) begin
                        loadState    <= LD_BUSY;
                        loadCount    <= 8'h00;
                        configLoaded <= 1'b0;
                    end
                end
                LD_BUSY: begin
                    if (loadCount == `LOAD_CYCLES - 8'h01) begin
                        loadState    <= LD_IDLE;
                        configLoaded <= 1'b1;
                        serialNum    <= SERIAL_DEFAULT;
                    end else begin
                        loadCount <= loadCount + 8'h01;
                    end
                end
                default: loadState <= LD_IDLE;
            endcase
        end
    end

    // (RL1) (RL2) charging port seen while suspended
    // set and clear conditions cannot meet in one cycle
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
            chargePortSeen <= 1'b0;
        else
            // (RL5) cleared once awake or enumerated
            chargePortSeen <= usbSuspend && !enumerated && dataLinesShorted ? 1'b1 :
                              (!usbSuspend || enumerated) ? 1'b0 : chargePortSeen;
    end

    // (RL8) (RL17) retriggerable lamp one-shots
    // each active cycle reloads the full stretch
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            txStretch <= 32'h0000_0000;
            rxStretch <= 32'h0000_0000;
        end else begin
            txStretch <= txActive ? LAMP_CYCLES : (txLamp ? txStretch - 32'h0000_0001 : txStretch);
            rxStretch <= rxActive ? LAMP_CYCLES : (rxLamp ? rxStretch - 32'h0000_0001 : rxStretch);
        end
    end

    // (RL12) remote wake resume pulse
    // wakeLatched allows one resume per suspend period
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wakeCount    <= 32'h0000_0000;
            resumeSignal <= 1'b0;
            wakeLatched  <= 1'b0;
        end else if (wakeCount != 32'h0000_0000) begin
            wakeCount    <= wakeCount - 32'h0000_0001;
            resumeSignal <= (wakeCount != 32'h0000_0001);
        end else if (options[`OPT_REMOTE_WAKE] && usbSuspend && !wake_line_n && !wakeLatched) begin
            wakeCount    <= WAKE_CYCLES;
            resumeSignal <= 1'b1;
            wakeLatched  <= 1'b1;
        end else begin
            resumeSignal <= 1'b0;
            wakeLatched  <= wakeLatched && usbSuspend;
        end
    end

    // (RL11) suspend pull-down of uart lines
    // follows suspend one edge later
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
            uartPullDown <= 1'b0;
        else
            uartPullDown <= options[`OPT_PULLDOWN] && usbSuspend;
    end

    // per-pin function mux
    // registered: a new function shows one edge later
    genvar p;
    generate
        for (p = 0; p < PINS; p = p + 1) begin : g_pin
            always @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    configPinOut[p] <= 1'b0;
                    configPinOe[p]  <= 1'b0;
                end else begin
                    case (pinFunc[4*p +: 4])
                        // (RL3) charger detect high
                        `FN_CHARGER: begin
                            configPinOut[p] <= chargePortSeen;
                            configPinOe[p]  <= 1'b1;
                        end
                        // (RL4) charger detect low
                        `FN_CHARGER_N: begin
                            configPinOut[p] <= !chargePortSeen;
                            configPinOe[p]  <= 1'b1;
                        end
                        // (RL6) (RL7) lamp drives low
                        `FN_TX_LAMP_N: begin
                            configPinOut[p] <= 1'b0;
                            configPinOe[p]  <= txLamp;
                        end
                        `FN_RX_LAMP_N: begin
                            configPinOut[p] <= 1'b0;
                            configPinOe[p]  <= rxLamp;
                        end
                        // (RL9) either direction
                        `FN_ACT_LAMP_N: begin
                            configPinOut[p] <= 1'b0;
                            configPinOe[p]  <= txLamp || rxLamp;
                        end
                        // (RL16) low in suspend
                        `FN_SUSPEND_IND_N: begin
                            configPinOut[p] <= !usbSuspend;
                            configPinOe[p]  <= 1'b1;
                        end
                        `FN_SUPPLY_SW_N: begin
                            configPinOut[p] <= usbSuspend;
                            configPinOe[p]  <= 1'b1;
                        end
                        // (RL18) unassigned floats
                        default: begin
                            configPinOut[p] <= 1'b0;
                            configPinOe[p]  <= 1'b0;
                        end
                    endcase
                end
            end
        end
    endgenerate

endmodule // config_pin_status_signal_logic

//--- src/config_pin_status_defines.vh
// constants for the configurable status pin block
`ifndef CONFIG_PIN_STATUS_DEFINES_VH
`define CONFIG_PIN_STATUS_DEFINES_VH

// register byte offsets
`define OFS_PIN_FUNC      8'h00
`define OFS_OPTIONS       8'h04
`define OFS_STATUS        8'h08
`define OFS_DESC_INFO     8'h0C
`define OFS_SERIAL        8'h10
`define OFS_LOAD_CTRL     8'h14

// pin function codes (4 bits per pin)
`define FN_TRISTATE       4'h0
`define FN_CHARGER        4'h1
`define FN_CHARGER_N      4'h2
`define FN_TX_LAMP_N      4'h3
`define FN_RX_LAMP_N      4'h4
`define FN_ACT_LAMP_N     4'h5
`define FN_SUSPEND_IND_N  4'h6
`define FN_SUPPLY_SW_N    4'h7

// reset values
`define RST_PIN_FUNC      16'h6340
`define RST_OPTIONS       32'h0000_0006

// option bit positions
`define OPT_PULLDOWN      0
`define OPT_REMOTE_WAKE   1
`define OPT_SERIAL_EN     2
`define OPT_SELF_POWER    3

// descriptor defaults
`define DESC_USB_VERSION  16'h0200
`define DESC_MAX_POWER_MA 8'h5A

// timing
`define CLK_HZ            40000000
`define LAMP_MS           50
`define RESUME_MS         20
`define LOAD_CYCLES       8'h40

// bus responses
`define RESP_OKAY         2'b00
`define RESP_SLVERR       2'b10

`endif

//--- verification/config_pin_status_chk.sv
// checker for the status pin block ports
`timescale 1ns/10ps
module config_pin_status_chk #(
    parameter WAKE_CYCLES = 10
) (
    // clock, reset, bus
    input wire        clk,
    input wire        sys_rst,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    // status
    input wire        usbBusReset,
    input wire        usbSuspend,
    input wire        wake_line_n,
    input wire        resumeSignal,
    input wire        configLoaded,
    input wire        uartPullDown
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    reg [7:0]  loadCnt;
    reg [31:0] hiCnt;
    // cycles since reset or bus reset, saturating
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) loadCnt <= 8'h00;
        else if (usbBusReset) loadCnt <= 8'h00;
        else if (loadCnt != 8'h64) loadCnt <= loadCnt + 8'h01;
    end
    // length of the current resume pulse
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) hiCnt <= 32'h0000_0000;
        else hiCnt <= resumeSignal ? hiCnt + 32'h0000_0001 : 32'h0000_0000;
    end
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    property p_load_wait; (loadCnt < 8'h3C) |-> !configLoaded; endproperty
    property p_load_done; (loadCnt == 8'h50) |-> configLoaded; endproperty
    property p_pull_off; (!usbSuspend) [*2] |-> !uartPullDown; endproperty
    property p_wake_cause;
        $rose(resumeSignal) |-> $past(usbSuspend) && (!$past(wake_line_n) || !$past(wake_line_n, 2));
    endproperty
    property p_wake_len; $fell(resumeSignal) |-> hiCnt == WAKE_CYCLES; endproperty
    property p_bresp; s_wr_taken |=> s_axi_bvalid; endproperty
    property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
    property p_rvalid; s_rd_taken |=> s_axi_rvalid; endproperty
    property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_load_wait: assert property (p_load_wait) else $error("config loaded too early");
    a_load_done: assert property (p_load_done) else $error("config load never finished");
    a_pull_off: assert property (p_pull_off) else $error("pull-down outside suspend");
    a_wake_cause: assert property (p_wake_cause) else $error("resume without wake request");
    a_wake_len: assert property (p_wake_len) else $error("resume pulse length wrong");
    a_bresp: assert property (p_bresp) else $error("write response late");
    a_bhold: assert property (p_bhold) else $error("write response dropped or unstable");
    a_rvalid: assert property (p_rvalid) else $error("read answer late");
    a_rhold: assert property (p_rhold) else $error("read data dropped");
endmodule // config_pin_status_chk

//--- verification/usb_far_side.sv
// model of host link, charger and lamps beside the block
`timescale 1ns/10ps
module usb_far_side (
    input  wire       clk,
    input  wire [3:0] configPinOut,
    input  wire [3:0] configPinOe,
    output reg        usbBusReset,
    output reg        usbSuspend,
    output reg        dataLinesShorted,
    output reg        enumerated,
    output reg        txActive,
    output reg        rxActive,
    output reg        wake_line_n,
    output wire [3:0] pinLevel
);
    // pull-ups at lamps and charger enable
    assign pinLevel = (configPinOe & configPinOut) | ~configPinOe;
    initial begin
        {usbBusReset, usbSuspend, dataLinesShorted, enumerated, txActive, rxActive} = 6'h00;
        wake_line_n = 1'b1;
    end
    // link: 0 enumerated host, 1 charging port, 2 host suspend
    task set_link(input [1:0] m);
        begin
            @(posedge clk);
            dataLinesShorted <= (m == 2'd1);
            usbSuspend       <= (m != 2'd0);
            enumerated       <= (m != 2'd1);
        end
    endtask
    // one cycle of data movement
    task pulse(input t, input r);
        begin
            @(posedge clk);
            txActive <= t;
            rxActive <= r;
            @(posedge clk);
            txActive <= 1'b0;
            rxActive <= 1'b0;
        end
    endtask
    task bus_reset;
        begin
            @(posedge clk) usbBusReset <= 1'b1;
            repeat (2) @(posedge clk);
            usbBusReset <= 1'b0;
        end
    endtask
endmodule // usb_far_side

//--- verification/tb.sv
// testbench for the status pin block
`timescale 1ns/10ps
`include "config_pin_status_defines.vh"
module tb;
    localparam LAMP = 20;
    reg clk = 1'b0, sys_rst = 1'b1;
    reg [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    reg [31:0] s_axi_wdata = 32'h0000_0000, rd;
    reg [3:0] s_axi_wstrb = 4'hf;
    reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    reg [1:0] resp;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire usbBusReset, usbSuspend, dataLinesShorted, enumerated, txActive, rxActive, wake_line_n;
    wire resumeSignal, configLoaded, uartPullDown;
    wire [3:0] configPinOut, configPinOe, pinLevel;
    integer failures = 0, num_checks = 0, i, k;
    reg [3:0] fn [0:3];
    reg seen;
    always #12.5 clk = ~clk;
    config_pin_status_signal_logic #(.LAMP_CYCLES(LAMP), .WAKE_CYCLES(10)) DUT (.clk(clk), .sys_rst(sys_rst),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .usbBusReset(usbBusReset), .usbSuspend(usbSuspend), .dataLinesShorted(dataLinesShorted),
        .enumerated(enumerated), .resumeSignal(resumeSignal), .configLoaded(configLoaded), .txActive(txActive),
        .rxActive(rxActive), .wake_line_n(wake_line_n), .uartPullDown(uartPullDown),
        .configPinOut(configPinOut), .configPinOe(configPinOe));
    usb_far_side far (.clk(clk), .configPinOut(configPinOut), .configPinOe(configPinOe), .usbBusReset(usbBusReset),
        .usbSuspend(usbSuspend), .dataLinesShorted(dataLinesShorted), .enumerated(enumerated),
        .txActive(txActive), .rxActive(rxActive), .wake_line_n(wake_line_n), .pinLevel(pinLevel));
    task check(input [31:0] seenVal, input [31:0] expVal);
        begin
            num_checks = num_checks + 1;
            if (seenVal !== expVal) begin
                $display("unexpected at %0t: seen %h expected %h", $time, seenVal, expVal);
                failures = failures + 1;
            end
        end
    endtask
    task print_verdict;
        begin
            $display("checks %0d mismatches %0d", num_checks, failures);
            if (failures == 0 && num_checks > 0) $display("SIMULATION PASSED");
            else $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    task waitc(input integer n);
        begin
            repeat (n) @(posedge clk);
        end
    endtask
    // write both channels together, hold each until taken
    task wr(input [7:0] a, input [31:0] d);
        reg awDone, wDone;
        begin
            s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1;
            awDone = 1'b0; wDone = 1'b0;
            while (!(awDone && wDone)) begin
                @(posedge clk);
                if (s_axi_awvalid && s_axi_awready) begin awDone = 1'b1; s_axi_awvalid <= 1'b0; end
                if (s_axi_wvalid && s_axi_wready) begin wDone = 1'b1; s_axi_wvalid <= 1'b0; end
            end
            @(posedge clk);
            s_axi_bready <= 1'b1;
            do @(posedge clk); while (s_axi_bvalid !== 1'b1);
            resp = s_axi_bresp;
            s_axi_bready <= 1'b0;
        end
    endtask
    task rdr(input [7:0] a);
        begin
            s_axi_araddr <= a; s_axi_arvalid <= 1'b1;
            do @(posedge clk); while (s_axi_arready !== 1'b1);
            s_axi_arvalid <= 1'b0;
            @(posedge clk);
            s_axi_rready <= 1'b1;
            do @(posedge clk); while (s_axi_rvalid !== 1'b1);
            rd = s_axi_rdata; resp = s_axi_rresp;
            s_axi_rready <= 1'b0;
        end
    endtask
    // watchdog on a hung run
    initial begin
        #500000;
        failures = failures + 1;
        print_verdict;
    end
    initial begin
        fn[0] = `FN_CHARGER; fn[1] = `FN_CHARGER_N; fn[2] = `FN_SUSPEND_IND_N;
        fn[3] = `FN_SUPPLY_SW_N;
        waitc(4);
        sys_rst <= 1'b0;
        waitc(1);
        rdr(`OFS_PIN_FUNC); check(rd, 32'h0000_6340);
        rdr(`OFS_OPTIONS); check(rd, `RST_OPTIONS);
        rdr(`OFS_DESC_INFO); check(rd, 32'h0200_005A);
        rdr(8'h20); check({rd[29:0], resp}, {30'h0, `RESP_SLVERR});
        wr(8'h24, 32'h0000_0001); check({30'h0, resp}, {30'h0, `RESP_SLVERR});
        k = 0;
        while (configLoaded !== 1'b1 && k < 200) begin waitc(1); k = k + 1; end
        check({31'h0, configLoaded}, 32'h0000_0001);
        rdr(`OFS_SERIAL); check(rd, 32'h1234_5678);
        // lamps: pin0 activity, pin1 receive, pin2 transmit, pin3 charger
        wr(`OFS_PIN_FUNC, 32'h0000_1345);
        far.pulse(1'b1, 1'b0); waitc(2);
        check({29'h0, configPinOe[2:0]}, 32'h0000_0005);
        check({29'h0, configPinOut[2:0] & configPinOe[2:0]}, 32'h0000_0000);
        waitc(5); far.pulse(1'b1, 1'b0); waitc(LAMP - 3);
        check({29'h0, configPinOe[2:0]}, 32'h0000_0005);
        waitc(8); check({29'h0, configPinOe[2:0]}, 32'h0000_0000);
        far.pulse(1'b0, 1'b1); waitc(2); check({29'h0, configPinOe[2:0]}, 32'h0000_0003);
        // charger, active-low charger, suspend indicator, supply switch on pin3
        for (i = 0; i < 4; i = i + 1) begin
            wr(`OFS_PIN_FUNC, {16'h0, fn[i], 12'h345});
            for (k = 1; k >= 0; k = k - 1) begin
                far.set_link(k); waitc(3);
                seen = (fn[i] == `FN_CHARGER) ? (configPinOe[3] & configPinOut[3]) :
                       (fn[i] == `FN_SUPPLY_SW_N) ? pinLevel[3] : ~pinLevel[3];
                check({31'h0, seen}, k);
                if (i == 0) check({31'h0, uartPullDown}, 32'h0000_0000);
            end
        end
        wr(`OFS_OPTIONS, 32'h0000_0003); far.set_link(2'd1); waitc(3);
        check({31'h0, uartPullDown}, 32'h0000_0001);
        far.set_link(2'd0); waitc(3); check({31'h0, uartPullDown}, 32'h0000_0000);
        // wake request with remote wake on, then off
        for (i = 1; i >= 0; i = i - 1) begin
            wr(`OFS_OPTIONS, {30'h0, i[0], 1'b0}); far.set_link(2'd0); far.set_link(2'd2); waitc(3);
            @(posedge clk) far.wake_line_n <= 1'b0;
            seen = 1'b0;
            for (k = 0; k < 20; k = k + 1) begin waitc(1); seen = seen | (resumeSignal === 1'b1); end
            far.wake_line_n <= 1'b1;
            check({31'h0, seen}, i);
        end
        wr(`OFS_PIN_FUNC, 32'h0000_0000); waitc(3); check({28'h0, configPinOe}, 32'h0000_0000);
        far.bus_reset; waitc(2); check({31'h0, configLoaded}, 32'h0000_0000);
        rdr(`OFS_LOAD_CTRL); check(rd, 32'h0000_0001);
        waitc(100); check({31'h0, configLoaded}, 32'h0000_0001);
        rdr(`OFS_STATUS); check(rd, 32'h0000_0022);
        print_verdict;
    end
endmodule // tb
bind config_pin_status_signal_logic config_pin_status_chk #(.WAKE_CYCLES(WAKE_CYCLES)) u_chk (.clk(clk), .sys_rst(sys_rst),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .usbBusReset(usbBusReset), .usbSuspend(usbSuspend), .wake_line_n(wake_line_n),
    .resumeSignal(resumeSignal), .configLoaded(configLoaded), .uartPullDown(uartPullDown));
